// *** logic/fpec_cfg.svh ***
// address map, field positions, reset values and timing counts of the flash sequencer
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH

`define FPEC_CTL_ADDR       16'hfe08
`define FPEC_STS_ADDR       16'hfe0d
`define FPEC_PROT_ADDR      16'hff7e
`define FPEC_PROT_IDX       14'h3f7e
`define FPEC_USER_LO        16'hc000
`define FPEC_USER_HI        16'hfdff
`define FPEC_VEC_LO         16'hffdc
`define FPEC_LAST_PAGE      10'h3ff
`define FPEC_ARRAY_WORDS    16384
`define FPEC_PAGE_WORDS     15'h0040
`define FPEC_MASS_WORDS     15'h4000

`define FPEC_CTL_PGM        0
`define FPEC_CTL_ERASE      1
`define FPEC_CTL_MASS       2
`define FPEC_CTL_HIGH_VOLTAGE_ENABLE       3
`define FPEC_CTL_RESET      4'h0

`define FPEC_STS_LATCHED    0
`define FPEC_STS_SETUP_MET  1
`define FPEC_STS_HV_MET     2
`define FPEC_STS_ERASING    3
`define FPEC_STS_READ_READY 4
`define FPEC_STS_PROT_READ  5
`define FPEC_STS_HOLD_MET   6
`define FPEC_STS_PROTECTED  7

`define FPEC_ERASED_BYTE    8'hff
`define FPEC_PROT_NONE      8'hff
`define FPEC_PROT_ALL       8'h00
`define FPEC_PROT_RESET     8'hff

`define FPEC_CLK_MHZ        200
`define FPEC_SETUP_BEFORE_HIGH_VOLTAGE_US       10
`define FPEC_T_ERASE_MS     4
`define FPEC_HIGH_VOLTAGE_RELEASE_HOLD_US       5
`define FPEC_T_NVHL_US      100
`define FPEC_READ_RECOVERY_TIME_US       1
`define FPEC_NVS_CYC        (`FPEC_SETUP_BEFORE_HIGH_VOLTAGE_US * `FPEC_CLK_MHZ)
`define FPEC_ERASE_CYC      (`FPEC_T_ERASE_MS * 1000 * `FPEC_CLK_MHZ)
`define FPEC_NVH_CYC        (`FPEC_HIGH_VOLTAGE_RELEASE_HOLD_US * `FPEC_CLK_MHZ)
`define FPEC_NVHL_CYC       (`FPEC_T_NVHL_US * `FPEC_CLK_MHZ)
`define FPEC_RCV_CYC        (`FPEC_READ_RECOVERY_TIME_US * `FPEC_CLK_MHZ)

`endif

// *** logic/fpec_pkg.sv ***
// types shared by the flash sequencer modules
package fpec_pkg;

	typedef enum logic [6:0] {
		FPEC_IDLE  = 7'h01,
		FPEC_SEL   = 7'h02,
		FPEC_PROT  = 7'h04,
		FPEC_LATCH = 7'h08,
		FPEC_HV    = 7'h10,
		FPEC_HOLD  = 7'h20,
		FPEC_RECOV = 7'h40
	} fpec_seq_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} fpec_bus_t;

	typedef struct packed {
		logic        wr;
		logic        erase;
		logic [13:0] waddr;
		logic [7:0]  wdata;
		logic        rd;
		logic [13:0] raddr;
		logic        byp;
		logic [7:0]  byp_data;
	} fpec_mem_req_t;

	typedef struct packed {
		fpec_seq_t   seq;
		logic [3:0]  ctl;
		logic [15:0] lat_addr;
		logic [7:0]  lat_data;
		logic [7:0]  prot;
		logic        prot_pend;
		logic        prot_seen;
		logic [13:0] walk_addr;
		logic [14:0] walk_left;
		logic        rdy;
	} fpec_state_t;

endpackage

// *** logic/fpec_mem.sv ***
// flash cell array with bit-clearing program, erase writes and a registered read port
`include "fpec_cfg.svh"

module fpec_mem (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire fpec_pkg::fpec_mem_req_t req,
	output logic [7:0]                   rdata
);

	logic [7:0] cells [0:`FPEC_ARRAY_WORDS-1];

	// parts leave the factory erased
	initial begin
		for (int i = 0; i < `FPEC_ARRAY_WORDS; i++) begin
			cells[i] = `FPEC_ERASED_BYTE;
		end
	end

	// programming can only pull bits to zero; only erase brings them back to one
	always_ff @(posedge clk) begin
		if (req.wr) begin
			if (req.erase) begin
				cells[req.waddr] <= `FPEC_ERASED_BYTE;
			end else begin
				cells[req.waddr] <= cells[req.waddr] & req.wdata;
			end
		end
	end

	// one register serves array reads and register reads alike
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			rdata <= cells[req.raddr];
		end else if (req.byp) begin
			rdata <= req.byp_data;
		end
	end

endmodule

// *** logic/fpec_tmr.sv ***
// down counter that flags when a loaded number of cycles has passed
module fpec_tmr #(
	parameter int WIDTH = 20
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] load,
	output logic                  done
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             done;
	} fpec_tmr_st_t;

	fpec_tmr_st_t st;
	fpec_tmr_st_t next_st;

	// done rises load+1 edges after start, so a minimum time is never cut short
	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt  = load;
			next_st.done = 1'b0;
		end else if (st.cnt != '0) begin
			next_st.cnt = st.cnt - 1'b1;
		end else begin
			next_st.done = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;

endmodule

// *** logic/fpec_top.sv ***
// flash erase/program sequencer: control register, sequence checker, timer and erase walker
`include "fpec_cfg.svh"

// Overview of operation
// - erased cells read one, programmed cells read zero
// - array holds 15,872 user bytes, 36 vector bytes, one protect byte, bytewide
// - page erase clears the 64 bytes of the two-row page to ones, except the protect byte
// - high-voltage enable sets only with a select bit and a correct sequence
// - high-voltage enable on runs the pump and drives the array, off stops both
// - whole-array bit one selects mass erase, zero selects page erase
// - erase select one sets the array up for erasing
// - program select one sets up programming and latching of address and data
// - erase select and program select are never both one
// - a write inside the page latches it; high voltage waits 10 us after
// - after erase clears wait 5 us (100 us for mass erase), drop high voltage, reads after 1 us
// - steps keep their order; unrelated bus traffic between them is harmless
// - page erase of the last page 0xFFC0-0xFFFF does nothing
// - protected target address blocks high-voltage enable for erase and program
module fpec_top #(
	parameter int unsigned ERASE_CYC     = `FPEC_ERASE_CYC,
	parameter int unsigned MASS_HOLD_CYC = `FPEC_NVHL_CYC
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic [7:0]       RDATA,
	output logic             CHARGE_PUMP_ON,
	output logic             ARRAY_HIGH_VOLTAGE,
	output logic             READ_READY
);

	localparam int TMR_W = 20;

	////////////////////////////////////////////////////////////////////////////////
	// reset release

	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// decode

	fpec_pkg::fpec_bus_t     bus;
	fpec_pkg::fpec_state_t   st;
	fpec_pkg::fpec_state_t   next_st;
	fpec_pkg::fpec_mem_req_t mem_req;
	logic                    is_flash;
	logic                    prot_hit;
	logic [15:0]             prot_start;
	logic                    last_page;
	logic                    row_match;
	logic                    tmr_start;
	logic [TMR_W-1:0]        tmr_load;
	logic                    tmr_done;
	logic                    sel_rise;
	logic                    sel_any;
	logic                    hv_ok;
	logic [7:0]              sts;

	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// only user space, the protect byte and the vectors are array cells
	assign is_flash = ((bus.addr >= `FPEC_USER_LO) && (bus.addr <= `FPEC_USER_HI))
		|| (bus.addr == `FPEC_PROT_ADDR)
		|| (bus.addr >= `FPEC_VEC_LO);

	// protected range runs from the coded page boundary up to the top of the array
	assign prot_start = {2'b11, st.prot, 6'h00};
	assign prot_hit   = (st.prot != `FPEC_PROT_NONE)
		&& (st.ctl[`FPEC_CTL_MASS] || (st.prot == `FPEC_PROT_ALL)
		|| (st.lat_addr >= prot_start) || (st.lat_addr == `FPEC_PROT_ADDR));

	assign last_page = (st.lat_addr[15:6] == `FPEC_LAST_PAGE);
	assign row_match = (bus.addr[15:5] == st.lat_addr[15:5]);

	assign sts = {prot_hit,
		(st.seq == fpec_pkg::FPEC_HOLD) && tmr_done,
		st.prot_seen,
		st.rdy,
		st.walk_left != 15'h0000,
		(st.seq == fpec_pkg::FPEC_HV) && tmr_done,
		(st.seq == fpec_pkg::FPEC_LATCH) && tmr_done,
		st.seq == fpec_pkg::FPEC_LATCH};

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_st           = st;
		mem_req           = '0;
		tmr_start         = 1'b0;
		tmr_load          = '0;
		sel_rise          = 1'b0;
		sel_any           = 1'b0;
		hv_ok             = 1'b0;
		next_st.prot_pend = 1'b0;

		// protect byte arrives from the array one cycle after its read
		if (st.prot_pend) begin
			next_st.prot      = RDATA;
			next_st.prot_seen = 1'b1;
		end

		// array and register reads
		if (bus.rd) begin
			if (is_flash) begin
				mem_req.rd    = 1'b1;
				mem_req.raddr = bus.addr[13:0];
			end else begin
				mem_req.byp = 1'b1;
				if (bus.addr == `FPEC_CTL_ADDR) begin
					mem_req.byp_data = {4'h0, st.ctl};
				end else if (bus.addr == `FPEC_STS_ADDR) begin
					mem_req.byp_data = sts;
				end else begin
					mem_req.byp_data = 8'h00;
				end
			end
		end

		// control register writes
		if (bus.wr && (bus.addr == `FPEC_CTL_ADDR)) begin
			next_st.ctl[`FPEC_CTL_MASS] = bus.wdata[`FPEC_CTL_MASS];
			if (!(bus.wdata[`FPEC_CTL_PGM] && bus.wdata[`FPEC_CTL_ERASE])) begin
				next_st.ctl[`FPEC_CTL_PGM]   = bus.wdata[`FPEC_CTL_PGM];
				next_st.ctl[`FPEC_CTL_ERASE] = bus.wdata[`FPEC_CTL_ERASE];
			end
			sel_any = next_st.ctl[`FPEC_CTL_PGM] || next_st.ctl[`FPEC_CTL_ERASE];
			// setup time, protection and sequence must all be met
			hv_ok   = sel_any && (st.seq == fpec_pkg::FPEC_LATCH) && tmr_done && !prot_hit;
			if (!bus.wdata[`FPEC_CTL_HIGH_VOLTAGE_ENABLE]) begin
				next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE] = 1'b0;
			end else if (!st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE] && hv_ok) begin
				next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE] = 1'b1;
			end
		end
		sel_any  = next_st.ctl[`FPEC_CTL_PGM] || next_st.ctl[`FPEC_CTL_ERASE];
		sel_rise = (next_st.ctl[`FPEC_CTL_PGM] && !st.ctl[`FPEC_CTL_PGM])
			|| (next_st.ctl[`FPEC_CTL_ERASE] && !st.ctl[`FPEC_CTL_ERASE]);

		// erase walker: one cell per cycle, never touching the protect byte
		if (st.walk_left != 15'h0000) begin
			if (st.walk_addr != `FPEC_PROT_IDX) begin
				mem_req.wr    = 1'b1;
				mem_req.erase = 1'b1;
				mem_req.waddr = st.walk_addr;
			end
			next_st.walk_addr = st.walk_addr + 14'h0001;
			next_st.walk_left = st.walk_left - 15'h0001;
		end

		// only accesses that belong to the next step move the sequence
		unique case (st.seq)
			fpec_pkg::FPEC_IDLE: begin
				if (sel_rise) begin
					next_st.seq = fpec_pkg::FPEC_SEL;
				end
			end
			fpec_pkg::FPEC_SEL: begin
				if (!sel_any) begin
					next_st.seq = fpec_pkg::FPEC_IDLE;
				end else if (bus.rd && (bus.addr == `FPEC_PROT_ADDR)) begin
					next_st.seq       = fpec_pkg::FPEC_PROT;
					next_st.prot_pend = 1'b1;
				end
			end
			fpec_pkg::FPEC_PROT: begin
				if (!sel_any) begin
					next_st.seq = fpec_pkg::FPEC_IDLE;
				end else if (sel_rise) begin
					next_st.seq = fpec_pkg::FPEC_SEL;
				end else if (bus.wr && is_flash) begin
					next_st.seq      = fpec_pkg::FPEC_LATCH;
					next_st.lat_addr = bus.addr;
					next_st.lat_data = bus.wdata;
					tmr_start        = 1'b1;
					tmr_load         = TMR_W'(`FPEC_NVS_CYC);
				end
			end
			fpec_pkg::FPEC_LATCH: begin
				if (!sel_any) begin
					next_st.seq = fpec_pkg::FPEC_IDLE;
				end else if (sel_rise) begin
					next_st.seq = fpec_pkg::FPEC_SEL;
				end else if (next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE]) begin
					next_st.seq = fpec_pkg::FPEC_HV;
					next_st.rdy = 1'b0;
					tmr_start   = 1'b1;
					tmr_load    = TMR_W'(ERASE_CYC);
				end
			end
			fpec_pkg::FPEC_HV: begin
				if (!next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE]) begin
					next_st.seq = fpec_pkg::FPEC_RECOV;
					tmr_start   = 1'b1;
					tmr_load    = TMR_W'(`FPEC_RCV_CYC);
				end else if (st.ctl[`FPEC_CTL_ERASE] && !next_st.ctl[`FPEC_CTL_ERASE]) begin
					// an erase cut short of its high-voltage time leaves the cells alone
					if (tmr_done) begin
						if (st.ctl[`FPEC_CTL_MASS]) begin
							next_st.walk_addr = 14'h0000;
							next_st.walk_left = `FPEC_MASS_WORDS;
						end else if (!last_page) begin
							next_st.walk_addr = {st.lat_addr[13:6], 6'h00};
							next_st.walk_left = `FPEC_PAGE_WORDS;
						end
					end
					next_st.seq = fpec_pkg::FPEC_HOLD;
					tmr_start   = 1'b1;
					tmr_load    = st.ctl[`FPEC_CTL_MASS] ? TMR_W'(MASS_HOLD_CYC) : TMR_W'(`FPEC_NVH_CYC);
				end else if (st.ctl[`FPEC_CTL_PGM] && !next_st.ctl[`FPEC_CTL_PGM]) begin
					next_st.seq = fpec_pkg::FPEC_HOLD;
					tmr_start   = 1'b1;
					tmr_load    = TMR_W'(`FPEC_NVH_CYC);
				end else if (st.ctl[`FPEC_CTL_PGM] && bus.wr && is_flash && row_match
					&& !prot_hit && (st.walk_left == 15'h0000)) begin
					mem_req.wr    = 1'b1;
					mem_req.waddr = bus.addr[13:0];
					mem_req.wdata = bus.wdata;
				end
			end
			fpec_pkg::FPEC_HOLD: begin
				if (!next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE]) begin
					next_st.seq = fpec_pkg::FPEC_RECOV;
					tmr_start   = 1'b1;
					tmr_load    = TMR_W'(`FPEC_RCV_CYC);
				end
			end
			fpec_pkg::FPEC_RECOV: begin
				if (tmr_done) begin
					next_st.seq = fpec_pkg::FPEC_IDLE;
					next_st.rdy = 1'b1;
				end
			end
			default: begin
				next_st.seq = fpec_pkg::FPEC_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st      <= '0;
			st.seq  <= fpec_pkg::FPEC_IDLE;
			st.ctl  <= `FPEC_CTL_RESET;
			st.prot <= `FPEC_PROT_RESET;
			st.rdy  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// high-voltage outputs

	// both follow the enable flop directly so the pump never outlives the bit
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			CHARGE_PUMP_ON     <= 1'b0;
			ARRAY_HIGH_VOLTAGE <= 1'b0;
			READ_READY         <= 1'b1;
		end else begin
			CHARGE_PUMP_ON     <= next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE];
			ARRAY_HIGH_VOLTAGE <= next_st.ctl[`FPEC_CTL_HIGH_VOLTAGE_ENABLE];
			READ_READY         <= next_st.rdy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	fpec_tmr #(
		.WIDTH (TMR_W)
	) u_tmr (
		.clk   (SYS_CLK),
		.rst_n (rst_n),
		.start (tmr_start),
		.load  (tmr_load),
		.done  (tmr_done)
	);

	fpec_mem u_mem (
		.clk   (SYS_CLK),
		.rst_n (rst_n),
		.req   (mem_req),
		.rdata (RDATA)
	);

endmodule

// *** tb/fpec_props.sv ***
// assertion checker for the flash sequencer ports
`include "fpec_cfg.svh"
module fpec_props #(
	parameter int unsigned ERASE_CYC     = 50,
	parameter int unsigned MASS_HOLD_CYC = 30
) (
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	input wire logic        CHARGE_PUMP_ON,
	input wire logic        ARRAY_HIGH_VOLTAGE,
	input wire logic        READ_READY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////
	a_pump_array_same: assert property (
		CHARGE_PUMP_ON == ARRAY_HIGH_VOLTAGE) else $error("pump and array voltage differ");
	a_hv_rise_cause: assert property (
		$rose(CHARGE_PUMP_ON) |-> $past(WR) && $past(ADDR) == `FPEC_CTL_ADDR
		&& ($past(WDATA) & 8'h08) != 8'h00) else $error("pump rose without enable write");
	a_hv_drop_write: assert property (
		CHARGE_PUMP_ON && WR && ADDR == `FPEC_CTL_ADDR && !WDATA[3] |-> ##2 !CHARGE_PUMP_ON)
		else $error("pump stayed on after enable cleared");
	a_ready_low_hv: assert property (
		CHARGE_PUMP_ON && $past(CHARGE_PUMP_ON) |-> !READ_READY) else $error("read ready during high voltage");
	a_ready_recover: assert property (
		$fell(CHARGE_PUMP_ON) |-> !READ_READY [*8] ##[1:300] READ_READY)
		else $error("read recovery wrong");
	a_rdata_hold: assert property (
		!$past(RD) |-> $stable(RDATA)) else $error("read data changed without read");
	a_ctl_no_both: assert property (
		$past(RD) && $past(ADDR) == `FPEC_CTL_ADDR |-> RDATA[1:0] != 2'b11 && RDATA[7:4] == 4'h0)
		else $error("control shows both selects or upper bits");
	a_unmapped_zero: assert property (
		$past(RD) && $past(ADDR) < 16'hc000 |-> RDATA == 8'h00) else $error("unmapped read not zero");
	a_ctl_hv_mirror: assert property (
		$past(RD) && $past(ADDR) == `FPEC_CTL_ADDR |-> RDATA[3] == CHARGE_PUMP_ON)
		else $error("enable bit and pump disagree");
endmodule

// *** tb/fpec_cpu.sv ***
// behavioural cpu driving the sequencer bus through the erase and program steps
`include "fpec_cfg.svh"
module fpec_cpu (
	input  wire logic           clk,
	input  wire logic [7:0]     rdata,
	input  wire logic           pump,
	input  wire logic           rdy,
	output fpec_pkg::fpec_bus_t bus
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus = '0;
	end
	task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd_b(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// o = {ready at end, ready while on, pump on, pump after too-early try}
	task automatic op(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] d, output logic [3:0] o);
		logic [7:0] p;
		int         n;
		wr_b(`FPEC_CTL_ADDR, sel);
		rd_b(`FPEC_PROT_ADDR, p);
		wr_b(a, 8'h00);
		rd_b(16'h1234, p);
		// early try lands ten cycles short of the setup time
		repeat (1985) @(posedge clk);
		wr_b(`FPEC_CTL_ADDR, sel | 8'h08);
		repeat (2) @(posedge clk);
		o[0] = pump;
		repeat (15) @(posedge clk);
		wr_b(`FPEC_CTL_ADDR, sel | 8'h08);
		repeat (2) @(posedge clk);
		o[1] = pump;
		o[2] = rdy;
		repeat (30) @(posedge clk);
		if (sel[0]) begin
			wr_b(a, d);
		end
		repeat (60) @(posedge clk);
		// keep the whole-array bit; the erase type is taken from its value before this write
		wr_b(`FPEC_CTL_ADDR, (sel & 8'h04) | 8'h08);
		repeat (1001) @(posedge clk);
		wr_b(`FPEC_CTL_ADDR, 8'h00);
		for (n = 0; n < 400 && rdy !== 1'b1; n++) begin
			@(posedge clk);
		end
		o[3] = rdy;
	endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the flash sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic        wr;
		logic [15:0] a;
		logic [7:0]  d;
		logic [7:0]  e;
	} fpec_row_t;
	logic                clk;
	logic                rst_b;
	fpec_pkg::fpec_bus_t bus;
	logic [7:0]          rdata;
	logic                pump;
	logic                hv;
	logic                rdy;
	logic [7:0]          r;
	logic [3:0]          o;
	int                  fails = 0;
	int                  cmp_count = 0;
	fpec_row_t           rows [13] = '{
		'{1'b0, 16'hfe08, 8'h00, 8'h00},
		'{1'b1, 16'hfe0d, 8'hff, 8'h10},
		'{1'b0, 16'hc000, 8'h00, 8'hff},
		'{1'b0, 16'hfffe, 8'h00, 8'hff},
		'{1'b1, 16'hfe08, 8'h04, 8'h04},
		'{1'b1, 16'hfe08, 8'h03, 8'h00},
		'{1'b1, 16'hfe08, 8'h02, 8'h02},
		'{1'b1, 16'hfe08, 8'h03, 8'h02},
		'{1'b1, 16'hfe08, 8'h0a, 8'h02},
		'{1'b1, 16'hfe08, 8'h01, 8'h01},
		'{1'b1, 16'hfe08, 8'hf2, 8'h02},
		'{1'b1, 16'hfe08, 8'h00, 8'h00},
		'{1'b1, 16'h1234, 8'h55, 8'h00}
	};
	////////////////////////////////////////
	fpec_top #(.ERASE_CYC(50), .MASS_HOLD_CYC(30)) dut_u (
		.SYS_CLK           (clk),
		.RST_B             (rst_b),
		.ADDR              (bus.addr),
		.WDATA             (bus.wdata),
		.WR                (bus.wr),
		.RD                (bus.rd),
		.RDATA             (rdata),
		.CHARGE_PUMP_ON    (pump),
		.ARRAY_HIGH_VOLTAGE(hv),
		.READ_READY        (rdy)
	);
	fpec_cpu cpu_u (.clk(clk), .rdata(rdata), .pump(pump), .rdy(rdy), .bus(bus));
	////////////////////////////////////////
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpu_u.rd_b(a, d);
		chk(11'(d), 11'(e));
	endtask
	task automatic finish_test();
		$display("checks=%0d fails=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// a full run is about 40k cycles
	initial begin
		#400000;
		fails++;
		finish_test();
	end
	initial begin
		rst_b = 1'b0;
		repeat (3) @(posedge clk);
		chk(11'({rdata, pump, hv, rdy}), 11'h001);
		rst_b <= 1'b1;
		repeat (5) @(posedge clk);
		for (int i = 0; i < 13; i++) begin
			if (rows[i].wr) begin
				cpu_u.wr_b(rows[i].a, rows[i].d);
			end
			cpu_u.rd_b(rows[i].a, r);
			chk(11'(r), 11'(rows[i].e));
		end
		cpu_u.op(8'h01, 16'hc041, 8'h5a, o);
		chk(11'(o), 11'h00a);
		cpu_u.op(8'h01, 16'hc080, 8'h00, o);
		cpu_u.op(8'h01, 16'hffe0, 8'h00, o);
		rc(16'hc041, 8'h5a);
		cpu_u.op(8'h02, 16'hc07f, 8'h00, o);
		chk(11'(o), 11'h00a);
		rc(16'hc041, 8'hff);
		rc(16'hc080, 8'h00);
		cpu_u.op(8'h02, 16'hffe0, 8'h00, o);
		rc(16'hffe0, 8'h00);
		cpu_u.op(8'h06, 16'hc000, 8'h00, o);
		// the mass walker clears one cell a cycle, far past the shortened hold time
		r = 8'hff;
		for (int k = 0; k < 8000 && r[3] !== 1'b0; k++) begin
			cpu_u.rd_b(16'hfe0d, r);
		end
		chk(11'(r[3]), 11'h000);
		rc(16'hffe0, 8'hff);
		rc(16'hc080, 8'hff);
		cpu_u.op(8'h01, 16'hff7e, 8'h01, o);
		rc(16'hff7e, 8'h01);
		cpu_u.op(8'h02, 16'hc040, 8'h00, o);
		chk(11'(o), 11'h00c);
		finish_test();
	end
endmodule

bind fpec_top fpec_props #(
	.ERASE_CYC    (ERASE_CYC),
	.MASS_HOLD_CYC(MASS_HOLD_CYC)
) props_u (
	.SYS_CLK           (SYS_CLK),
	.RST_B             (RST_B),
	.ADDR              (ADDR),
	.WDATA             (WDATA),
	.WR                (WR),
	.RD                (RD),
	.RDATA             (RDATA),
	.CHARGE_PUMP_ON    (CHARGE_PUMP_ON),
	.ARRAY_HIGH_VOLTAGE(ARRAY_HIGH_VOLTAGE),
	.READ_READY        (READ_READY)
);
